// *** verilog/bbx_exec.sv ***
`timescale 1ns/1ns
// Summary of operation
// RULE1 - B arithmetic right shift keeps bit 7, shifts others down, bit 0 out.
// RULE2 - after B shift, carry takes former bit 0 of B.
// RULE3 - after B shift, overflow equals negative XOR carry of the result.
// RULE4 - shift and bit-clear set N from bit 7, Z on zero; clear forces V low.
// RULE5 - opcode 24 branches only when carry is 0.
// RULE6 - opcode 25 branches only when carry is 1.
// RULE7 - opcode 27 branches on zero set; opcode 26 on zero clear.
// RULE8 - taken branch loads PC with branch address plus 2 plus offset.
// RULE9 - taken branch uses three fetch cycles; not taken uses one.
// RULE10 - 2C/2D test N XOR V; 2E/2F test Z OR (N XOR V).
// RULE11 - signed greater-equal branch follows register at least memory after compare.
// RULE12 - 22/23 test carry OR zero; 24/25 test carry.
// RULE13 - 2B/2A test negative, 29/28 overflow, 20 always, 21 never.
// RULE14 - branch offset byte is sign-extended to 16 bits.
// RULE15 - bit-clear reads byte, clears bits with mask 1, writes back.
// RULE16 - bit-clear leaves bits with mask 0 unchanged.
// RULE17 - mask byte sits 2, 3 or 4 past opcode by addressing mode.
// RULE18 - bit-clear decodes 4D, 1D, 0D; indirect indexed forms are refused.
module bbx_exec
    import bbx_pkg::*;
(
    // clock, reset, enable
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       clk_en_in,
    // instruction from decode
    input  wire logic       instr_valid_in,
    input  wire logic [7:0] opcode_in,
    input  wire logic [15:0] instr_addr_in,
    input  wire logic [7:0] rel_offset_in,
    input  wire bbx_idx_t   idx_class_in,
    input  wire logic [15:0] eff_addr_in,
    // accumulator b and flags
    input  wire logic [7:0] acc_b_in,
    input  bbx_flags_t      flags_in,
    // program byte and memory port
    input  wire logic [7:0] prog_byte_in,
    input  wire logic [7:0] mem_rdata_in,
    input  wire logic       mem_ack_in,
    // results
    output logic            busy_out,
    output logic            done_out,
    output logic            illegal_out,
    output logic [7:0]      acc_b_out,
    output logic            acc_b_we_out,
    output bbx_flags_t      flags_out,
    output logic            flags_we_out,
    output logic [15:0]     pc_out,
    output logic            pc_we_out,
    output logic            prog_fetch_out,
    output logic [2:0]      prog_ofs_out,
    output logic [15:0]     mem_addr_out,
    output logic            mem_rd_out,
    output logic            mem_wr_out,
    output logic [7:0]      mem_wdata_out
);
    bbx_state_t  state_r,  state_nxt;
    logic [1:0]  fetch_r,  fetch_nxt;
    logic [7:0]  mask_r,   mask_nxt;
    logic [7:0]  data_r,   data_nxt;
    logic [15:0] addr_r,   addr_nxt;
    logic [2:0]  ofs_r,    ofs_nxt;
    logic        clr_r,    clr_nxt;
    logic [7:0]  acc_b_nxt;
    logic        acc_b_we_nxt, done_nxt, illegal_nxt, pc_we_nxt, flags_we_nxt;
    logic [15:0] pc_nxt;
    bbx_flags_t  flags_nxt;
    logic        is_branch, taken, is_clear;
    logic [7:0]  alu_res;
    bbx_flags_t  alu_flags;

    // branch condition evaluation
    bbx_cond_eval u_cond (
        .opcode_in     (opcode_in),
        .flags_in      (flags_in),
        .is_branch_out (is_branch),
        .taken_out     (taken)
    );

    // shared shift / bit-clear datapath
    bbx_alu8 u_alu (
        .opnd_in      (clr_r ? data_r : acc_b_in),
        .mask_in      (mask_r),
        .sel_clear_in (clr_r),
        .flags_in     (flags_in),
        .result_out   (alu_res),
        .flags_out    (alu_flags)
    );

    // bit-clear opcode decode
    assign is_clear = (opcode_in == OP_CLEAR_BITS_DIRECT) ||
                      (opcode_in == OP_CLEAR_BITS_EXTENDED) ||
                      (opcode_in == OP_CLEAR_BITS_INDEXED); // RULE18

    // sequencer next state
    always_comb
    begin
        state_nxt    = state_r;
        fetch_nxt    = fetch_r;
        mask_nxt     = mask_r;
        data_nxt     = data_r;
        addr_nxt     = addr_r;
        ofs_nxt      = ofs_r;
        clr_nxt      = clr_r;
        acc_b_nxt    = acc_b_out;
        acc_b_we_nxt = 1'b0;
        flags_nxt    = flags_out;
        flags_we_nxt = 1'b0;
        pc_nxt       = pc_out;
        pc_we_nxt    = 1'b0;
        done_nxt     = 1'b0;
        illegal_nxt  = 1'b0;
        unique case (state_r)
            BBX_IDLE:
            begin
                clr_nxt = 1'b0;
                if (instr_valid_in)
                begin
                    if (opcode_in == OP_SHIFT_RIGHT_ARITH_ACC_B)
                    begin
                        acc_b_nxt    = alu_res;          // RULE1
                        acc_b_we_nxt = 1'b1;
                        flags_nxt    = alu_flags;        // RULE2 RULE3 RULE4
                        flags_we_nxt = 1'b1;
                        done_nxt     = 1'b1;
                    end
                    else if (is_branch)
                    begin
                        if (taken)
                        begin
                            // RULE8 RULE14
                            pc_nxt    = instr_addr_in + BRANCH_PC_STEP
                                        + {{8{rel_offset_in[MSB_POS]}}, rel_offset_in};
                            pc_we_nxt = 1'b1;
                            fetch_nxt = TAKEN_FETCH_CYCLES;     // RULE9
                        end
                        else
                        begin
                            fetch_nxt = NOT_TAKEN_FETCH_CYCLES; // RULE9
                        end
                        state_nxt = BBX_FETCH;
                    end
                    else if (is_clear)
                    begin
                        if ((opcode_in == OP_CLEAR_BITS_INDEXED) &&
                            (idx_class_in == BBX_IDX_INDIR))
                        begin
                            illegal_nxt = 1'b1;          // RULE18
                            done_nxt    = 1'b1;
                        end
                        else
                        begin
                            // RULE17
                            if (opcode_in == OP_CLEAR_BITS_EXTENDED ||
                                (opcode_in == OP_CLEAR_BITS_INDEXED &&
                                 idx_class_in == BBX_IDX_9BIT))
                                ofs_nxt = MASK_OFS_MID;
                            else if (opcode_in == OP_CLEAR_BITS_INDEXED &&
                                     idx_class_in == BBX_IDX_16BIT)
                                ofs_nxt = MASK_OFS_LONG;
                            else
                                ofs_nxt = MASK_OFS_SHORT;
                            addr_nxt  = eff_addr_in;
                            state_nxt = BBX_READ;
                        end
                    end
                    else
                    begin
                        illegal_nxt = 1'b1;
                        done_nxt    = 1'b1;
                    end
                end
            end
            BBX_FETCH:
            begin
                fetch_nxt = fetch_r - 2'h1;
                if (fetch_r == NOT_TAKEN_FETCH_CYCLES)
                begin
                    state_nxt = BBX_DONE;
                end
            end
            BBX_READ:
            begin
                if (mem_ack_in)
                begin
                    mask_nxt  = prog_byte_in;            // RULE17
                    data_nxt  = mem_rdata_in;            // RULE15
                    clr_nxt   = 1'b1;
                    state_nxt = BBX_WRITE;
                end
            end
            BBX_WRITE:
            begin
                if (mem_ack_in)
                begin
                    flags_nxt    = alu_flags;            // RULE4
                    flags_we_nxt = 1'b1;
                    state_nxt    = BBX_DONE;
                end
            end
            BBX_DONE:
            begin
                clr_nxt   = 1'b0;
                done_nxt  = 1'b1;
                state_nxt = BBX_IDLE;
            end
            default:
            begin
                state_nxt = BBX_IDLE;
            end
        endcase
    end

    // combinational handshakes and memory port
    assign busy_out       = (state_r != BBX_IDLE);
    assign prog_fetch_out = (state_r == BBX_FETCH) || (state_r == BBX_READ);
    assign prog_ofs_out   = ofs_r;
    assign mem_addr_out   = addr_r;
    assign mem_rd_out     = (state_r == BBX_READ);
    assign mem_wr_out     = (state_r == BBX_WRITE);               // RULE15
    assign mem_wdata_out  = alu_res;                               // RULE16

    // state registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_r      <= BBX_IDLE;
            fetch_r      <= 2'h0;
            mask_r       <= 8'h00;
            data_r       <= 8'h00;
            addr_r       <= 16'h0000;
            ofs_r        <= 3'h0;
            clr_r        <= 1'b0;
            acc_b_out    <= 8'h00;
            acc_b_we_out <= 1'b0;
            flags_out    <= '0;
            flags_we_out <= 1'b0;
            pc_out       <= 16'h0000;
            pc_we_out    <= 1'b0;
            done_out     <= 1'b0;
            illegal_out  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_r      <= state_nxt;
            fetch_r      <= fetch_nxt;
            mask_r       <= mask_nxt;
            data_r       <= data_nxt;
            addr_r       <= addr_nxt;
            ofs_r        <= ofs_nxt;
            clr_r        <= clr_nxt;
            acc_b_out    <= acc_b_nxt;
            acc_b_we_out <= acc_b_we_nxt;
            flags_out    <= flags_nxt;
            flags_we_out <= flags_we_nxt;
            pc_out       <= pc_nxt;
            pc_we_out    <= pc_we_nxt;
            done_out     <= done_nxt;
            illegal_out  <= illegal_nxt;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_taken_fetch_count: assert property ( // RULE9
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in && is_branch && taken)
        ##1 clk_en_in[*4] |-> $past(prog_fetch_out, 3) && $past(prog_fetch_out, 2)
            && $past(prog_fetch_out) && !prog_fetch_out ##1 done_out)
        else $error("taken branch fetch count wrong");
    chk_nottaken_fetch: assert property ( // RULE9
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in && is_branch && !taken)
        ##1 clk_en_in[*2] |-> $past(prog_fetch_out) && !prog_fetch_out ##1 done_out)
        else $error("untaken branch fetch count wrong");
    chk_branch_target: assert property ( // RULE8
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in && is_branch && taken)
        |=> pc_we_out && pc_out == $past(instr_addr_in) + BRANCH_PC_STEP
            + {{8{$past(rel_offset_in[7])}}, $past(rel_offset_in)})
        else $error("branch target wrong");
    chk_no_pc_untaken: assert property ( // RULE5
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in
         && opcode_in == OP_BRANCH_ON_CARRY_CLEAR && flags_in.carry) |=> !pc_we_out)
        else $error("carry-clear branch taken with carry set");
    chk_carry_set_br: assert property ( // RULE6
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in
         && opcode_in == OP_BRANCH_ON_CARRY_SET) |=> pc_we_out == $past(flags_in.carry))
        else $error("carry-set branch decision wrong");
    chk_shift_result: assert property ( // RULE1
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in
         && opcode_in == OP_SHIFT_RIGHT_ARITH_ACC_B)
        |=> acc_b_we_out && acc_b_out == {$past(acc_b_in[7]), $past(acc_b_in[7:1])})
        else $error("b shift result wrong");
    chk_shift_flags: assert property ( // RULE3
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in
         && opcode_in == OP_SHIFT_RIGHT_ARITH_ACC_B)
        |=> flags_out.carry == $past(acc_b_in[0])
            && flags_out.ovf == (flags_out.neg ^ flags_out.carry))
        else $error("b shift flags wrong");
    chk_clear_write: assert property ( // RULE15
        (clk_en_in && mem_rd_out && mem_ack_in) |=> mem_wr_out
            && mem_wdata_out == ($past(mem_rdata_in) & ~$past(prog_byte_in)))
        else $error("bit clear write data wrong");
    chk_clear_flags: assert property ( // RULE4
        (clk_en_in && mem_wr_out && mem_ack_in) |=> flags_we_out && !flags_out.ovf
            && flags_out.zero == ($past(mem_wdata_out) == 8'h00))
        else $error("bit clear flags wrong");
    chk_indirect_refused: assert property ( // RULE18
        (clk_en_in && state_r == BBX_IDLE && instr_valid_in
         && opcode_in == OP_CLEAR_BITS_INDEXED && idx_class_in == BBX_IDX_INDIR)
        |=> illegal_out && state_r == BBX_IDLE)
        else $error("indirect bit clear not refused");

    cov_taken: cover property (pc_we_out);
    cov_clear: cover property (mem_wr_out && mem_ack_in);
    cov_shift: cover property (acc_b_we_out);
    cov_illegal: cover property (illegal_out);
endmodule

// *** shared/bbx_pkg.sv ***
package bbx_pkg;
    // opcodes handled by this block
    localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_ACC_B = 8'h57;
    localparam logic [7:0] OP_BRANCH_ALWAYS           = 8'h20;
    localparam logic [7:0] OP_BRANCH_NEVER            = 8'h21;
    localparam logic [7:0] OP_BRANCH_UNSIGNED_HIGHER  = 8'h22;
    localparam logic [7:0] OP_BRANCH_UNSIGNED_LOW_SAME = 8'h23;
    localparam logic [7:0] OP_BRANCH_ON_CARRY_CLEAR   = 8'h24;
    localparam logic [7:0] OP_BRANCH_ON_CARRY_SET     = 8'h25;
    localparam logic [7:0] OP_BRANCH_ON_NOT_EQUAL     = 8'h26;
    localparam logic [7:0] OP_BRANCH_ON_EQUAL         = 8'h27;
    localparam logic [7:0] OP_BRANCH_ON_OVERFLOW_CLR  = 8'h28;
    localparam logic [7:0] OP_BRANCH_ON_OVERFLOW_SET  = 8'h29;
    localparam logic [7:0] OP_BRANCH_ON_POSITIVE      = 8'h2A;
    localparam logic [7:0] OP_BRANCH_ON_NEGATIVE      = 8'h2B;
    localparam logic [7:0] OP_BRANCH_SIGNED_GREATER_EQ = 8'h2C;
    localparam logic [7:0] OP_BRANCH_SIGNED_LESS      = 8'h2D;
    localparam logic [7:0] OP_BRANCH_SIGNED_GREATER   = 8'h2E;
    localparam logic [7:0] OP_BRANCH_SIGNED_LESS_EQ   = 8'h2F;
    localparam logic [7:0] OP_CLEAR_BITS_DIRECT       = 8'h4D;
    localparam logic [7:0] OP_CLEAR_BITS_EXTENDED     = 8'h1D;
    localparam logic [7:0] OP_CLEAR_BITS_INDEXED      = 8'h0D;
    // branch and mask geometry
    localparam logic [15:0] BRANCH_PC_STEP            = 16'h0002;
    localparam logic [1:0]  TAKEN_FETCH_CYCLES        = 2'h3;
    localparam logic [1:0]  NOT_TAKEN_FETCH_CYCLES    = 2'h1;
    localparam logic [2:0]  MASK_OFS_SHORT            = 3'h2;
    localparam logic [2:0]  MASK_OFS_MID              = 3'h3;
    localparam logic [2:0]  MASK_OFS_LONG             = 3'h4;
    localparam int          MSB_POS                   = 7;

    // condition code flags used by this block
    typedef struct packed {
        logic neg;
        logic zero;
        logic ovf;
        logic carry;
    } bbx_flags_t;

    // indexed post-byte length class chosen by decode
    typedef enum logic [1:0] {
        BBX_IDX_SHORT = 2'b00,
        BBX_IDX_9BIT  = 2'b01,
        BBX_IDX_16BIT = 2'b10,
        BBX_IDX_INDIR = 2'b11
    } bbx_idx_t;

    // sequencer states
    typedef enum logic [2:0] {
        BBX_IDLE  = 3'b000,
        BBX_FETCH = 3'b001,
        BBX_READ  = 3'b010,
        BBX_WRITE = 3'b011,
        BBX_DONE  = 3'b100
    } bbx_state_t;
endpackage

// *** verilog/bbx_cond_eval.sv ***
`timescale 1ns/1ns
module bbx_cond_eval
    import bbx_pkg::*;
(
    // decoded opcode and current flags
    input  wire logic [7:0] opcode_in,
    input  bbx_flags_t      flags_in,
    // result
    output logic            is_branch_out,
    output logic            taken_out
);
    logic nv;

    // branch condition table
    always_comb
    begin
        nv            = flags_in.neg ^ flags_in.ovf;
        is_branch_out = 1'b1;
        taken_out     = 1'b0;
        unique case (opcode_in)
            OP_BRANCH_ALWAYS:            taken_out = 1'b1;              // RULE13
            OP_BRANCH_NEVER:             taken_out = 1'b0;              // RULE13
            OP_BRANCH_UNSIGNED_HIGHER:   taken_out = ~(flags_in.carry | flags_in.zero); // RULE12
            OP_BRANCH_UNSIGNED_LOW_SAME: taken_out = flags_in.carry | flags_in.zero;    // RULE12
            OP_BRANCH_ON_CARRY_CLEAR:    taken_out = ~flags_in.carry;  // RULE5
            OP_BRANCH_ON_CARRY_SET:      taken_out = flags_in.carry;   // RULE6
            OP_BRANCH_ON_NOT_EQUAL:      taken_out = ~flags_in.zero;   // RULE7
            OP_BRANCH_ON_EQUAL:          taken_out = flags_in.zero;    // RULE7
            OP_BRANCH_ON_OVERFLOW_CLR:   taken_out = ~flags_in.ovf;    // RULE13
            OP_BRANCH_ON_OVERFLOW_SET:   taken_out = flags_in.ovf;     // RULE13
            OP_BRANCH_ON_POSITIVE:       taken_out = ~flags_in.neg;    // RULE13
            OP_BRANCH_ON_NEGATIVE:       taken_out = flags_in.neg;     // RULE13
            OP_BRANCH_SIGNED_GREATER_EQ: taken_out = ~nv;              // RULE10 RULE11
            OP_BRANCH_SIGNED_LESS:       taken_out = nv;               // RULE10
            OP_BRANCH_SIGNED_GREATER:    taken_out = ~(flags_in.zero | nv); // RULE10
            OP_BRANCH_SIGNED_LESS_EQ:    taken_out = flags_in.zero | nv;    // RULE10
            default:                     is_branch_out = 1'b0;
        endcase
    end
endmodule

// *** verilog/bbx_alu8.sv ***
`timescale 1ns/1ns
module bbx_alu8
    import bbx_pkg::*;
(
    // operands
    input  wire logic [7:0] opnd_in,
    input  wire logic [7:0] mask_in,
    input  wire logic       sel_clear_in,
    input  bbx_flags_t      flags_in,
    // result
    output logic [7:0]      result_out,
    output bbx_flags_t      flags_out
);
    // shift or bit-clear with flag update
    always_comb
    begin
        flags_out = flags_in;
        if (sel_clear_in)
        begin
            result_out    = opnd_in & ~mask_in;              // RULE15 RULE16
            flags_out.ovf = 1'b0;                            // RULE4
        end
        else
        begin
            result_out      = {opnd_in[MSB_POS], opnd_in[MSB_POS:1]}; // RULE1
            flags_out.carry = opnd_in[0];                    // RULE2
            flags_out.ovf   = result_out[MSB_POS] ^ opnd_in[0]; // RULE3
        end
        flags_out.neg  = result_out[MSB_POS];                // RULE4
        flags_out.zero = (result_out == 8'h00);              // RULE4
    end
endmodule

// *** sim/bbx_exec_bench.sv ***
`timescale 1ns/1ns
module bbx_exec_bench
    import bbx_pkg::*;
();
    // clock, reset and request inputs
    logic        ref_clk_in;
    logic        rst_b_in;
    logic        clk_en_in;
    logic        instr_valid_in;
    logic [7:0]  opcode_in;
    logic [15:0] instr_addr_in;
    logic [7:0]  rel_offset_in;
    bbx_idx_t    idx_class_in;
    logic [15:0] eff_addr_in;
    logic [7:0]  acc_b_in;
    bbx_flags_t  flags_in;
    logic [7:0]  prog_byte_in;
    logic [7:0]  mem_rdata_in;
    logic        mem_ack_in;
    // design outputs
    logic        busy_out;
    logic        done_out;
    logic        illegal_out;
    logic [7:0]  acc_b_out;
    logic        acc_b_we_out;
    bbx_flags_t  flags_out;
    logic        flags_we_out;
    logic [15:0] pc_out;
    logic        pc_we_out;
    logic        prog_fetch_out;
    logic [2:0]  prog_ofs_out;
    logic [15:0] mem_addr_out;
    logic        mem_rd_out;
    logic        mem_wr_out;
    logic [7:0]  mem_wdata_out;
    // what one operation showed at the ports
    int          err_total;
    int          check_count;
    logic [15:0] n_fetch;
    logic [15:0] n_pcwe;
    logic [15:0] n_flg;
    logic [15:0] n_rd;
    logic [15:0] n_busy;
    logic [15:0] pc_seen;
    logic [7:0]  acc_seen;
    bbx_flags_t  flg_seen;
    logic [2:0]  ofs_seen;
    logic [15:0] addr_seen;
    logic [7:0]  wd_seen;
    logic        ill;

    bbx_exec uut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
        .instr_valid_in(instr_valid_in), .opcode_in(opcode_in), .instr_addr_in(instr_addr_in),
        .rel_offset_in(rel_offset_in), .idx_class_in(idx_class_in), .eff_addr_in(eff_addr_in),
        .acc_b_in(acc_b_in), .flags_in(flags_in), .prog_byte_in(prog_byte_in),
        .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in), .busy_out(busy_out),
        .done_out(done_out), .illegal_out(illegal_out), .acc_b_out(acc_b_out),
        .acc_b_we_out(acc_b_we_out), .flags_out(flags_out), .flags_we_out(flags_we_out),
        .pc_out(pc_out), .pc_we_out(pc_we_out), .prog_fetch_out(prog_fetch_out),
        .prog_ofs_out(prog_ofs_out), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
        .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out));

    // 20 MHz clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // issue the staged instruction, serve memory with a stall, record until done
    task automatic run(input int stall);
        int   wait_n;
        logic fin;
        logic ack_n;
        wait_n = 0;
        fin = 1'b0;
        n_fetch = '0; n_pcwe = '0; n_flg = '0; n_rd = '0; ill = 1'b0;
        n_busy = '0;
        acc_seen = 'x;
        // let an edge pass so valid is never lowered and raised in one step
        @(posedge ref_clk_in);
        #5;
        instr_valid_in = 1'b1;
        @(posedge ref_clk_in);
        #5;
        instr_valid_in = 1'b0;
        for (int i = 0; i < 40 && !fin; i++)
        begin
            if (prog_fetch_out === 1'b1) n_fetch++;
            if (busy_out === 1'b1) n_busy++;
            if (pc_we_out === 1'b1) begin n_pcwe++; pc_seen = pc_out; end
            if (acc_b_we_out === 1'b1) acc_seen = acc_b_out;
            if (flags_we_out === 1'b1) begin n_flg++; flg_seen = flags_out; end
            if (illegal_out === 1'b1) ill = 1'b1;
            ack_n = 1'b0;
            if (mem_rd_out === 1'b1 || mem_wr_out === 1'b1)
            begin
                if (mem_rd_out === 1'b1)
                begin
                    n_rd++;
                    ofs_seen = prog_ofs_out;
                    addr_seen = mem_addr_out;
                end
                else
                    wd_seen = mem_wdata_out;
                if (wait_n == stall) begin ack_n = 1'b1; wait_n = 0; end
                else wait_n++;
            end
            mem_ack_in = ack_n;
            if (done_out === 1'b1) fin = 1'b1;
            else begin @(posedge ref_clk_in); #5; end
        end
        if (!fin)
        begin
            err_total++;
            $display("[FAIL] %0t operation never completed", $time);
            stop_test();
        end
    endtask

    // expected branch decision from the flag tests
    function automatic logic br_take(input logic [7:0] op, input bbx_flags_t f);
        logic b;
        case (op[3:1])
            3'h0: b = 1'b1;
            3'h1: b = !(f.carry | f.zero);
            3'h2: b = !f.carry;
            3'h3: b = !f.zero;
            3'h4: b = !f.ovf;
            3'h5: b = !f.neg;
            3'h6: b = !(f.neg ^ f.ovf);
            default: b = !(f.zero | (f.neg ^ f.ovf));
        endcase
        return b ^ op[0];
    endfunction

    // b shift right on sign, zero and boundary values
    task automatic t_shift();
        logic [7:0] v[6] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hFE, 8'h7F};
        foreach (v[i])
        begin
            opcode_in = OP_SHIFT_RIGHT_ARITH_ACC_B;
            acc_b_in = v[i];
            flags_in = 4'hA ^ v[i][3:0];
            run(0);
            chk({8'h00, acc_seen}, {8'h00, v[i][7], v[i][7:1]});
            chk(n_flg, 16'h0001);
            chk({12'h000, flg_seen}, {12'h000, v[i][7], ~|v[i][7:1], v[i][7] ^ v[i][0], v[i][0]});
        end
    endtask

    // every branch opcode against every flag set, offsets of both signs
    task automatic t_branch();
        logic tk;
        for (int o = 32; o < 48; o++)
            for (int f = 0; f < 16; f++)
            begin
                opcode_in = o[7:0];
                flags_in = f[3:0];
                instr_addr_in = {o[3:0], 12'hFF8};
                rel_offset_in = {f[2:1], 6'h3D};
                tk = br_take(o[7:0], f[3:0]);
                run(0);
                chk(n_pcwe, {15'h0000, tk});
                chk(n_fetch, tk ? 16'h0003 : 16'h0001);
                chk(n_busy, tk ? 16'h0004 : 16'h0002);
                if (tk)
                    chk(pc_seen, instr_addr_in + 16'h0002 + {{8{rel_offset_in[7]}}, rel_offset_in});
            end
    endtask

    // signed greater-equal after a compare of r with m
    task automatic t_signed();
        logic [7:0] r[6] = '{8'h05, 8'hFD, 8'h02, 8'h80, 8'h7F, 8'h00};
        logic [7:0] m[6] = '{8'h05, 8'h02, 8'hFD, 8'h7F, 8'h80, 8'h01};
        logic [7:0] d;
        foreach (r[i])
        begin
            d = r[i] - m[i];
            flags_in = {d[7], d == 8'h00, (r[i][7] ^ m[i][7]) & (r[i][7] ^ d[7]), r[i] < m[i]};
            opcode_in = OP_BRANCH_SIGNED_GREATER_EQ;
            run(0);
            chk(n_pcwe, {15'h0000, $signed(r[i]) >= $signed(m[i])});
        end
    endtask

    // bit clear in every accepted form, with memory stalls
    task automatic t_clear();
        logic [7:0] ops[5] = '{8'h4D, 8'h1D, 8'h0D, 8'h0D, 8'h0D};
        bbx_idx_t   cls[5] = '{BBX_IDX_SHORT, BBX_IDX_SHORT, BBX_IDX_SHORT, BBX_IDX_9BIT,
                               BBX_IDX_16BIT};
        logic [2:0] ofs[5] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h4};
        logic [7:0] dat[5] = '{8'hA5, 8'h0F, 8'hF0, 8'h3C, 8'hFF};
        logic [7:0] msk[5] = '{8'h81, 8'hFF, 8'h0F, 8'h00, 8'h7E};
        logic [7:0] res;
        foreach (ops[i])
        begin
            opcode_in = ops[i];
            idx_class_in = cls[i];
            eff_addr_in = 16'h012A + 16'(i);
            mem_rdata_in = dat[i];
            prog_byte_in = msk[i];
            flags_in = {3'b010, i[0]};
            res = dat[i] & ~msk[i];
            run(i % 3);
            chk({13'h0000, ofs_seen}, {13'h0000, ofs[i]});
            chk(addr_seen, eff_addr_in);
            chk(n_rd, 16'(i % 3 + 1));
            chk({8'h00, wd_seen}, {8'h00, res});
            chk({12'h000, flg_seen}, {12'h000, res[7], res == 8'h00, 1'b0, i[0]});
            chk({15'h0000, ill}, 16'h0000);
        end
    endtask

    // indirect indexed clear and an opcode outside the block are refused
    task automatic t_illegal();
        opcode_in = OP_CLEAR_BITS_INDEXED;
        idx_class_in = BBX_IDX_INDIR;
        run(0);
        chk({15'h0000, ill}, 16'h0001);
        chk(n_rd, 16'h0000);
        opcode_in = 8'h00;
        run(0);
        chk({15'h0000, ill}, 16'h0001);
    endtask

    // main sequence
    initial
    begin
        err_total = 0;
        check_count = 0;
        rst_b_in = 1'b0;
        clk_en_in = 1'b1;
        instr_valid_in = 1'b0;
        opcode_in = 8'h00;
        instr_addr_in = 16'h0000;
        rel_offset_in = 8'h00;
        idx_class_in = BBX_IDX_SHORT;
        eff_addr_in = 16'h0000;
        acc_b_in = 8'h00;
        flags_in = 4'h0;
        prog_byte_in = 8'h00;
        mem_rdata_in = 8'h00;
        mem_ack_in = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #5;
        rst_b_in = 1'b1;
        t_shift();
        t_branch();
        t_signed();
        t_clear();
        t_illegal();
        stop_test();
    end
endmodule
